/* File: hw/tmc_pkg.sv */
// Package for the timer module core: register map, field positions,
// reset values and the carriers shared by the design.
// Assumes an APB slave with 32-bit data and one register per aligned word, except channel values: low byte at base, high byte at base+1.
package tmc_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_STATUS_CONTROL  = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH      = 8'h04;
    localparam logic [7:0] ADDR_COUNT_LOW       = 8'h08;
    localparam logic [7:0] ADDR_WRAP_HIGH       = 8'h0c;
    localparam logic [7:0] ADDR_WRAP_LOW        = 8'h10;
    localparam logic [7:0] ADDR_CHAN_SC_BASE    = 8'h20;
    localparam logic [7:0] ADDR_CHAN_VALUE_BASE = 8'h40;
    localparam logic [7:0] ADDR_CHAN_STRIDE     = 8'h04;

    // Timer status/control fields
    localparam int OVF_BIT     = 7;
    localparam int OVF_IE_BIT  = 6;
    localparam int CENTER_BIT  = 5;
    localparam int CLKS_HI_BIT = 4;
    localparam int CLKS_LO_BIT = 3;
    localparam int PS_HI_BIT   = 2;

    // Channel status/control fields
    localparam int CH_FLAG_BIT = 7;
    localparam int CH_IE_BIT   = 6;
    localparam int CH_MSH_BIT  = 5;
    localparam int CH_MSL_BIT  = 4;
    localparam int CH_ELS_HI   = 3;
    localparam int CH_ELS_LO   = 2;

    // Clock source codes
    localparam logic [1:0] CLKS_NONE  = 2'h0;
    localparam logic [1:0] CLKS_BUS   = 2'h1;
    localparam logic [1:0] CLKS_FIXED = 2'h2;
    localparam logic [1:0] CLKS_EXT   = 2'h3;

    // Reset and special values
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] WRAP_RESET  = 16'h0000;
    localparam logic [15:0] FREE_TOP    = 16'hffff;
    localparam logic [15:0] FREE_PRETOP = 16'hfffe;
    localparam logic [7:0]  CTL_RESET   = 8'h00;
    localparam int          NUM_CHANNELS = 2;

    typedef struct packed {
        logic        flag;
        logic        arm;
        logic        ie;
        logic        msh;
        logic        msl;
        logic [1:0]  els;
        logic [15:0] value;
        logic [2:0]  pin_sync;
    } tmc_chan_t;

endpackage

/* File: hw/tmc_core.sv */
// Timer module core: coherent 16-bit counter, buffered wrap limit,
// overflow flag and per-channel status/control with event flags.
// Assumes an APB master on pclk; fixed_tick and debug_halt come from pclk logic,
// ext_clk and chan_in are asynchronous pins.
`timescale 1ns/1ns

// Contract
// - Reading either count byte latches both; other byte served from latch.
// - Count latch clears on reset and on any status/control write.
// - Reset or any write to a count byte zeroes count and unlatches.
// - Debug halt freezes count; reads show live count, latch state kept.
// - In halt, writes to status/control or count bytes still unlatch.
// - Up-counting, at wrap limit the next timer tick loads zero and sets overflow.
// - One wrap byte written suppresses overflow until the other byte arrives.
// - Wrap limit resets to zero, meaning free-running full range.
// - Wrap writes are buffered; with no clock, transfer at second byte.
// - With clock and center select off, transfer on step limit-1 to limit, or fffe to ffff.
// - Any status/control write clears wrap buffer latch state, halt or not.
// - In halt wrap writes go straight to limit; buffer flags held.
// - Capture channel flags on the selected active input edge.
// - Compare and PWM channels flag when count equals channel value.
// - PWM at 0% or 100% duty never sets the channel flag.
// - Channel interrupt requested while flag set and enable is one.
// - Flag clears by read-while-set then write 0; new event keeps it.
// - Writing 1 to flag does nothing; reset clears flag and enable.
// - Channel register: flag bit 7, enable bit 6, mode high bit 5.
// - Clock source 00 stops counting; others pick bus, fixed or external.
// - Overflow flag sets on wrap, clears by read then write 0.
// - Center select makes all channels up/down; else per-channel modes.
module tmc_core #(
    parameter int CHANNELS = tmc_pkg::NUM_CHANNELS
) (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Timer inputs
    input  wire logic                fixed_tick,
    input  wire logic                ext_clk,
    input  wire logic                debug_halt,
    input  wire logic [CHANNELS-1:0] chan_in,
    // Requests
    output logic                     timer_irq,
    output logic [CHANNELS-1:0]      chan_irq
);

    typedef struct packed {
        logic [6:0]                         ctl;
        logic                               ovf;
        logic                               ovf_arm;
        logic [15:0]                        count;
        logic                               down;
        logic [6:0]                         pre;
        logic [2:0]                         ext_sync;
        logic [15:0]                        limit;
        logic [7:0]                         wb_hi;
        logic [7:0]                         wb_lo;
        logic                               got_hi;
        logic                               got_lo;
        logic                               latched;
        logic [15:0]                        cbuf;
        tmc_pkg::tmc_chan_t [CHANNELS-1:0]  ch;
        logic [31:0]                        prdata;
        logic                               pready;
        logic                               pslverr;
        logic                               timer_irq;
        logic [CHANNELS-1:0]                chan_irq;
    } tmc_state_t;

    tmc_state_t s;
    tmc_state_t next_s;

    always_comb
    begin
        logic        setup_rd;
        logic        wr;
        logic        mapped;
        logic [1:0]  clks;
        logic [2:0]  ps;
        logic [6:0]  pmask;
        logic        src;
        logic        run;
        logic        tick;
        logic [15:0] top;
        logic [15:0] full;
        logic        ovf_event;
        logic        center;
        logic        ch_event;
        logic        pwm;
        logic [7:0]  ch_addr;
        logic [7:0]  val_addr;
        logic [7:0]  rbyte;
        next_s    = s;
        setup_rd  = psel && !penable && !pwrite;
        wr        = psel && penable && pwrite && s.pready;
        mapped    = 1'b0;
        rbyte     = 8'h00;
        clks      = s.ctl[tmc_pkg::CLKS_HI_BIT:tmc_pkg::CLKS_LO_BIT];
        ps        = s.ctl[tmc_pkg::PS_HI_BIT:0];
        center    = s.ctl[tmc_pkg::CENTER_BIT];
        pmask     = 7'(8'(8'h01 << ps) - 8'h01);
        ovf_event = 1'b0;
        ch_event  = 1'b0;
        src       = 1'b0;
        pwm       = 1'b0;
        ch_addr   = 8'h00;
        val_addr  = 8'h00;
        top       = (s.limit == tmc_pkg::WRAP_RESET) ? tmc_pkg::FREE_TOP : s.limit;
        full      = {s.wb_hi, s.wb_lo};

        // External clock pin: two flops, then edge detect on the second
        next_s.ext_sync = {s.ext_sync[1:0], ext_clk};

        case (clks)
            tmc_pkg::CLKS_BUS:   src = 1'b1;
            tmc_pkg::CLKS_FIXED: src = fixed_tick;
            tmc_pkg::CLKS_EXT:   src = s.ext_sync[1] && !s.ext_sync[2];
            default:             src = 1'b0;
        endcase
        run  = (clks != tmc_pkg::CLKS_NONE) && !debug_halt;
        tick = run && src && (s.pre == pmask);
        if (run && src)
        begin
            next_s.pre = (s.pre == pmask) ? 7'h00 : s.pre + 7'h01;
        end

        // buffered limit moves on the step into the limit
        if (tick && s.got_hi && s.got_lo && !center &&
            (s.limit == tmc_pkg::WRAP_RESET ? s.count == tmc_pkg::FREE_PRETOP : s.count == s.limit - 16'h0001))
        begin
            next_s.limit  = full;
            next_s.got_hi = 1'b0;
            next_s.got_lo = 1'b0;
        end

        if (tick)
        begin
            if (center)
            begin
                if (!s.down && s.count >= top)
                begin
                    next_s.down  = 1'b1;
                    next_s.count = s.count - 16'h0001;
                end
                else if (s.down && s.count <= 16'h0001)
                begin
                    next_s.down  = 1'b0;
                    next_s.count = tmc_pkg::COUNT_RESET;
                    ovf_event    = 1'b1;
                end
                else
                begin
                    next_s.count = s.down ? s.count - 16'h0001 : s.count + 16'h0001;
                end
            end
            // wrap to zero at the limit
            else if (s.count == top)
            begin
                next_s.count = tmc_pkg::COUNT_RESET;
                ovf_event    = 1'b1;
            end
            else
            begin
                next_s.count = s.count + 16'h0001;
            end
        end
        else if (!center)
        begin
            next_s.down = 1'b0;
        end

        // half-written limit masks the overflow event
        if (s.got_hi != s.got_lo)
        begin
            ovf_event = 1'b0;
        end

        // APB reads: data and side effects at the setup edge
        if (psel && !penable)
        begin
            mapped = (paddr == tmc_pkg::ADDR_STATUS_CONTROL) || (paddr == tmc_pkg::ADDR_COUNT_HIGH) ||
                     (paddr == tmc_pkg::ADDR_COUNT_LOW) || (paddr == tmc_pkg::ADDR_WRAP_HIGH) ||
                     (paddr == tmc_pkg::ADDR_WRAP_LOW);
            case (paddr)
                tmc_pkg::ADDR_STATUS_CONTROL:
                begin
                    rbyte = {s.ovf, s.ctl};
                    if (setup_rd && s.ovf)
                    begin
                        next_s.ovf_arm = 1'b1;
                    end
                end
                tmc_pkg::ADDR_COUNT_HIGH, tmc_pkg::ADDR_COUNT_LOW:
                begin
                    // live count in halt, latch untouched
                    if (debug_halt || !s.latched)
                    begin
                        rbyte = (paddr == tmc_pkg::ADDR_COUNT_HIGH) ? s.count[15:8] : s.count[7:0];
                    end
                    else
                    begin
                        rbyte = (paddr == tmc_pkg::ADDR_COUNT_HIGH) ? s.cbuf[15:8] : s.cbuf[7:0];
                    end
                    // first read latches, second read releases
                    if (setup_rd && !debug_halt)
                    begin
                        next_s.latched = !s.latched;
                        next_s.cbuf    = s.latched ? s.cbuf : s.count;
                    end
                end
                tmc_pkg::ADDR_WRAP_HIGH: rbyte = s.limit[15:8];
                tmc_pkg::ADDR_WRAP_LOW:  rbyte = s.limit[7:0];
                default:                 rbyte = 8'h00;
            endcase
        end

        // one copy of channel logic each
        for (int i = 0; i < CHANNELS; i++)
        begin
            ch_addr  = 8'(tmc_pkg::ADDR_CHAN_SC_BASE + 8'(i) * tmc_pkg::ADDR_CHAN_STRIDE);
            val_addr = 8'(tmc_pkg::ADDR_CHAN_VALUE_BASE + 8'(i) * tmc_pkg::ADDR_CHAN_STRIDE);
            next_s.ch[i].pin_sync = {s.ch[i].pin_sync[1:0], chan_in[i]};
            pwm = center || s.ch[i].msh;
            if (!pwm && !s.ch[i].msl)
            begin
                ch_event = (s.ch[i].els[0] && s.ch[i].pin_sync[1] && !s.ch[i].pin_sync[2]) ||
                           (s.ch[i].els[1] && !s.ch[i].pin_sync[1] && s.ch[i].pin_sync[2]);
            end
            // compare match on a counter step
            else
            begin
                ch_event = tick && (s.count == s.ch[i].value);
                // no flag at 0% or 100% duty
                if (pwm && (s.ch[i].value == 16'h0000 || s.ch[i].value > top))
                begin
                    ch_event = 1'b0;
                end
            end
            if (psel && !penable && paddr == ch_addr)
            begin
                mapped = 1'b1;
                rbyte  = {s.ch[i].flag, s.ch[i].ie, s.ch[i].msh, s.ch[i].msl, s.ch[i].els, 2'b00};
                if (setup_rd && s.ch[i].flag)
                begin
                    next_s.ch[i].arm = 1'b1;
                end
            end
            if (psel && !penable && (paddr == val_addr || paddr == 8'(val_addr + 8'h01)))
            begin
                mapped = 1'b1;
                rbyte  = (paddr == val_addr) ? s.ch[i].value[7:0] : s.ch[i].value[15:8];
            end
            if (wr && paddr == ch_addr)
            begin
                next_s.ch[i].ie  = pwdata[tmc_pkg::CH_IE_BIT];
                next_s.ch[i].msh = pwdata[tmc_pkg::CH_MSH_BIT];
                next_s.ch[i].msl = pwdata[tmc_pkg::CH_MSL_BIT];
                next_s.ch[i].els = pwdata[tmc_pkg::CH_ELS_HI:tmc_pkg::CH_ELS_LO];
                // write 0 after armed read clears; a 1 does nothing
                if (s.ch[i].arm && !pwdata[tmc_pkg::CH_FLAG_BIT])
                begin
                    next_s.ch[i].flag = 1'b0;
                    next_s.ch[i].arm  = 1'b0;
                end
            end
            if (wr && paddr == val_addr)
            begin
                next_s.ch[i].value[7:0] = pwdata[7:0];
            end
            if (wr && paddr == 8'(val_addr + 8'h01))
            begin
                next_s.ch[i].value[15:8] = pwdata[7:0];
            end
            // new event wins over clear and restarts the sequence
            if (ch_event)
            begin
                next_s.ch[i].flag = 1'b1;
                next_s.ch[i].arm  = 1'b0;
            end
            next_s.chan_irq[i] = next_s.ch[i].flag && next_s.ch[i].ie;
        end

        // APB writes take effect at the completing edge
        if (wr)
        begin
            case (paddr)
                tmc_pkg::ADDR_STATUS_CONTROL:
                begin
                    next_s.ctl = pwdata[6:0];
                    if (s.ovf_arm && !pwdata[tmc_pkg::OVF_BIT])
                    begin
                        next_s.ovf     = 1'b0;
                        next_s.ovf_arm = 1'b0;
                    end
                    next_s.latched = 1'b0;
                    next_s.got_hi  = 1'b0;
                    next_s.got_lo  = 1'b0;
                end
                tmc_pkg::ADDR_COUNT_HIGH, tmc_pkg::ADDR_COUNT_LOW:
                begin
                    // any data zeroes count and unlatches
                    next_s.count   = tmc_pkg::COUNT_RESET;
                    next_s.pre     = 7'h00;
                    next_s.down    = 1'b0;
                    next_s.latched = 1'b0;
                end
                tmc_pkg::ADDR_WRAP_HIGH, tmc_pkg::ADDR_WRAP_LOW:
                begin
                    if (debug_halt)
                    begin
                        if (paddr == tmc_pkg::ADDR_WRAP_HIGH)
                        begin
                            next_s.limit[15:8] = pwdata[7:0];
                        end
                        else
                        begin
                            next_s.limit[7:0] = pwdata[7:0];
                        end
                    end
                    else
                    begin
                        if (paddr == tmc_pkg::ADDR_WRAP_HIGH)
                        begin
                            next_s.wb_hi  = pwdata[7:0];
                            next_s.got_hi = 1'b1;
                        end
                        else
                        begin
                            next_s.wb_lo  = pwdata[7:0];
                            next_s.got_lo = 1'b1;
                        end
                        // no clock: take the pair at once
                        if (clks == tmc_pkg::CLKS_NONE && (next_s.got_hi && next_s.got_lo))
                        begin
                            next_s.limit  = {next_s.wb_hi, next_s.wb_lo};
                            next_s.got_hi = 1'b0;
                            next_s.got_lo = 1'b0;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end

        if (ovf_event)
        begin
            next_s.ovf     = 1'b1;
            next_s.ovf_arm = 1'b0;
        end
        next_s.timer_irq = next_s.ovf && next_s.ctl[tmc_pkg::OVF_IE_BIT];

        // Zero-wait slave: answer in the access cycle
        next_s.pready  = psel && !penable;
        next_s.pslverr = psel && !penable && !mapped;
        if (setup_rd)
        begin
            next_s.prdata = {24'h000000, rbyte};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s       <= '0;
            s.ctl   <= tmc_pkg::CTL_RESET[6:0];
            s.count <= tmc_pkg::COUNT_RESET;
            s.limit <= tmc_pkg::WRAP_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata    = s.prdata;
    assign pready    = s.pready;
    assign pslverr   = s.pslverr;
    assign timer_irq = s.timer_irq;
    assign chan_irq  = s.chan_irq;

endmodule

/* File: tb/tmc_monitor.sv */
// Assertion checker for the timer core: APB timing and request outputs.
// Assumes it is bound to tmc_core and sees only its ports.
`timescale 1ns/1ns
module tmc_monitor #(
    parameter int CHANNELS = 2
) (
    // Clock and reset
    input wire logic                pclk,
    input wire logic                presetn,
    // APB
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // Timer side
    input wire logic                fixed_tick,
    input wire logic                ext_clk,
    input wire logic                debug_halt,
    input wire logic [CHANNELS-1:0] chan_in,
    input wire logic                timer_irq,
    input wire logic [CHANNELS-1:0] chan_irq
);
    logic setup;
    logic wacc;

    assign setup = psel && !penable;
    assign wacc  = psel && penable && pwrite && pready;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    pready_after_setup_a: assert property (setup |=> pready)
        else $error("pready missing after setup");
    pready_single_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    pready_cause_a: assert property (pready |-> $past(setup) && psel && penable)
        else $error("pready without a setup");
    err_in_access_a: assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    rdata_hold_a: assert property ($changed(prdata) |-> $past(setup && !pwrite))
        else $error("prdata changed without read setup");
    rdata_upper_a: assert property (prdata[31:8] == 24'h000000)
        else $error("prdata upper bits not zero");
    ovf_irq_clear_a: assert property ($fell(timer_irq) |-> $past(wacc) || $past(wacc, 2))
        else $error("overflow request fell without write");
    chan_irq_clear_a: assert property ($fell(chan_irq[0]) |-> $past(wacc) || $past(wacc, 2))
        else $error("channel request fell without write");

    cover property ($rose(timer_irq));
    cover property ($rose(chan_irq[0]));
    cover property (pslverr);
endmodule

bind tmc_core tmc_monitor #(.CHANNELS(CHANNELS)) mon_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fixed_tick(fixed_tick), .ext_clk(ext_clk), .debug_halt(debug_halt), .chan_in(chan_in),
    .timer_irq(timer_irq), .chan_irq(chan_irq));

/* File: tb/tmc_core_tb.sv */
// Self-checking bench for the timer core over APB.
// Assumes fixed_tick is the only clock source used; ext_clk stays low.
`timescale 1ns/1ns
module tmc_core_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fixed_tick = 1'b0;
    logic        ext_clk = 1'b0;
    logic        debug_halt = 1'b0;
    logic [1:0]  chan_in = 2'h0;
    logic        timer_irq;
    logic [1:0]  chan_irq;
    int          err_count = 0;
    int          compares = 0;
    int          cyc = 0;
    logic [31:0] seed = 32'h00009cb7;
    logic [15:0] cnt = 16'h0000;
    logic [15:0] lim = 16'h0000;
    logic [15:0] old;
    logic [7:0]  rd;
    logic        er;
    logic        run = 1'b0;

    tmc_core #(.CHANNELS(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fixed_tick(fixed_tick), .ext_clk(ext_clk), .debug_halt(debug_halt),
        .chan_in(chan_in), .timer_irq(timer_irq), .chan_irq(chan_irq));

    always #20 pclk = ~pclk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    // Zero limit means the full 16-bit range
    function automatic logic [15:0] nxt(input logic [15:0] c, input logic [15:0] l);
        return (l != 16'h0000 && c == l) ? 16'h0000 : c + 16'h0001;
    endfunction

    task automatic report_and_stop();
        if (err_count == 0 && compares > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the cycle ceiling ends a wait for the slave
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk8(rd, e);
    endtask

    // Extra idle cycles give the enable time to reach the count
    task automatic tick(input int t);
        repeat (t)
        begin
            @(posedge pclk);
            fixed_tick <= 1'b1;
            @(posedge pclk);
            fixed_tick <= 1'b0;
            repeat (2) @(posedge pclk);
            if (run && !debug_halt) cnt = nxt(cnt, lim);
        end
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rchk(8'(i * 4 + (i > 4 ? 12 : 0)), 8'h00);
        end
        xfer(1'b0, 8'h18, 8'h00);
        chk1(er, 1'b1);
        wr(8'h00, 8'h10);
        run = 1'b1;
        repeat (3)
        begin
            seed = xs(seed);
            tick(int'(seed % 6) + 1);
            rchk(8'h08, cnt[7:0]);
            rchk(8'h04, cnt[15:8]);
        end
        old = cnt;
        rchk(8'h04, old[15:8]);
        tick(3);
        rchk(8'h08, old[7:0]);
        rchk(8'h08, cnt[7:0]);
        tick(1);
        wr(8'h00, 8'h10);
        rchk(8'h08, cnt[7:0]);
        rchk(8'h04, cnt[15:8]);
        rchk(8'h08, cnt[7:0]);
        debug_halt <= 1'b1;
        tick(2);
        rchk(8'h04, cnt[15:8]);
        wr(8'h00, 8'h10);
        debug_halt <= 1'b0;
        tick(1);
        rchk(8'h08, cnt[7:0]);
        rchk(8'h04, cnt[15:8]);
        seed = xs(seed);
        wr(8'h04, seed[7:0]);
        cnt = 16'h0000;
        rchk(8'h08, 8'h00);
        rchk(8'h04, 8'h00);
        wr(8'h00, 8'h00);
        wr(8'h0c, 8'h00);
        wr(8'h10, 8'h03);
        lim = 16'h0003;
        rchk(8'h10, 8'h03);
        wr(8'h08, 8'h00);
        cnt = 16'h0000;
        wr(8'h00, 8'h50);
        tick(3);
        rchk(8'h00, 8'h50);
        tick(1);
        rchk(8'h08, 8'h00);
        rchk(8'h00, 8'hd0);
        chk1(timer_irq, 1'b1);
        wr(8'h00, 8'h50);
        rchk(8'h00, 8'h50);
        chk1(timer_irq, 1'b0);
        wr(8'h0c, 8'h00);
        tick(4);
        rchk(8'h00, 8'h50);
        wr(8'h10, 8'h03);
        tick(4);
        rchk(8'h00, 8'hd0);
        wr(8'h00, 8'h00);
        run = 1'b0;
        tick(2);
        rchk(8'h08, cnt[7:0]);
        rchk(8'h04, 8'h00);
        wr(8'h08, 8'h00);
        cnt = 16'h0000;
        wr(8'h20, 8'h50);
        wr(8'h40, 8'h02);
        wr(8'h41, 8'h00);
        wr(8'h00, 8'h10);
        run = 1'b1;
        tick(3);
        rchk(8'h20, 8'hd0);
        chk1(chan_irq[0], 1'b1);
        wr(8'h20, 8'h50);
        rchk(8'h20, 8'h50);
        chk1(chan_irq[0], 1'b0);
        wr(8'h20, 8'hd0);
        rchk(8'h20, 8'h50);
        wr(8'h24, 8'h20);
        tick(4);
        rchk(8'h24, 8'h20);
        wr(8'h24, 8'h44);
        chan_in <= 2'h2;
        repeat (4) @(posedge pclk);
        rchk(8'h24, 8'hc4);
        chk1(chan_irq[1], 1'b1);
        // Halt reads must not release a pending latch
        old = cnt;
        rchk(8'h04, old[15:8]);
        debug_halt <= 1'b1;
        rchk(8'h04, cnt[15:8]);
        wr(8'h10, 8'h05);
        lim = 16'h0005;
        rchk(8'h10, 8'h05);
        debug_halt <= 1'b0;
        tick(1);
        rchk(8'h08, old[7:0]);
        // A control write drops the half-written high byte
        wr(8'h0c, 8'h00);
        wr(8'h00, 8'h10);
        wr(8'h10, 8'h04);
        tick(6);
        rchk(8'h10, 8'h05);
        wr(8'h08, 8'h00);
        wr(8'h00, 8'h30);
        tick(7);
        rchk(8'h08, 8'h03);
        report_and_stop();
    end
endmodule
